// *** rtl/psic_top.sv ***
/*
  selector and interrupt control registers with indexed register bank.
  assumes a synchronous host port: one-cycle rd/wr strobes, 16-bit words,
  and event pulses from the line engines, one cycle each; carrier and bell are levels.
*/
module psic_top #(
  parameter int PORTS = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // host register port
  input wire logic [4:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  // configuration straps
  input wire logic printer_type_in,
  input wire logic printer_present_in,
  input wire logic rate_table_in,
  // interrupt events
  input wire logic bus_error_in,
  input wire logic queue_age_in,
  input wire logic queue_alarm_in,
  input wire logic tx_done_in,
  input wire logic [15:0] carrier_in,
  input wire logic [15:0] bell_in,
  input wire logic printer_attention_in,
  // speed code lookup for the selected port
  input wire logic [3:0] speed_code_in,
  output logic [15:0] baud_out,
  // interrupt request and vector
  output logic irq_out,
  output logic [7:0] vector_out,
  // selected slot and clear status
  output logic [4:0] index_out,
  output logic clearing_out
);
  // all state except the indexed bank in one struct
  typedef struct packed {
    psic_pkg::psic_mode_e mode;
    logic [4:0] clr_cnt;
    logic multi;
    logic [4:0] index;
    logic [5:0] enable;
    logic [7:0] vector;
    logic [5:0] pending;
    logic [5:0] posted;
    logic [15:0] carrier_q;
    logic [15:0] bell_q;
    logic [15:0] rdata;
    logic rvalid;
    logic irq;
    logic [7:0] vec_out;
    logic [15:0] baud;
  } psic_state_s;

  psic_state_s st_ff;
  psic_state_s nxt_st;
  // indexed bank: param, printer state, addr hi, addr lo, length
  logic [15:0] bank_ff [psic_pkg::NUM_SLOTS][5];
  logic [15:0] baud_w;

  // highest priority set bit, bit 5 is bus fault
  function automatic logic [2:0] top_src(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < psic_pkg::NUM_SRC; i++) begin
      if (v[i]) begin
        r = 3'(5 - i);
      end
    end
    return r;
  endfunction

  // slot number of an indexed offset, 7 when not indexed
  function automatic logic [2:0] slot_of(input logic [4:0] a);
    logic [2:0] r;
    r = 3'h7;
    unique case (a)
      psic_pkg::OFS_PARAM: r = 3'h0;
      psic_pkg::OFS_PSTATE: r = 3'h1;
      psic_pkg::OFS_ADDR_HI: r = 3'h2;
      psic_pkg::OFS_ADDR_LO: r = 3'h3;
      psic_pkg::OFS_LEN: r = 3'h4;
      default: r = 3'h7;
    endcase
    return r;
  endfunction

  psic_rate u_rate (
    .table_in(rate_table_in),
    .code_in(speed_code_in),
    .baud_out(baud_w)
  );

  logic idx_ok;
  assign idx_ok = (st_ff.index <= psic_pkg::IDX_PRINTER);

  // next-state logic
  always_comb begin
    logic [5:0] ev;
    logic [5:0] req;
    logic [2:0] src;
    logic [2:0] sl;
    ev = 6'h00;
    req = 6'h00;
    src = 3'h0;
    sl = slot_of(addr_in);
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.carrier_q = carrier_in;
    nxt_st.bell_q = bell_in;
    nxt_st.baud = baud_w;
    // [R13] bits 5..0: fault, queue, tx, carrier, bell, printer
    // [R14] bus error sets fault
    ev[5] = bus_error_in;
    // [R15] age or alarm
    ev[4] = queue_age_in | queue_alarm_in;
    // [R16] all sent
    ev[3] = tx_done_in;
    // [R17] any edge of carrier or bell
    ev[2] = |(carrier_in ^ st_ff.carrier_q);
    ev[1] = |(bell_in ^ st_ff.bell_q);
    // [R18] printer attention
    ev[0] = printer_attention_in;
    // host read
    if (rd_in) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = 16'h0000;
      unique case (addr_in)
        psic_pkg::OFS_SEL: begin
          // [R7] [R8] [R9] configuration format, clear bit while busy
          nxt_st.rdata[psic_pkg::SEL_CLEAR_BIT] = (st_ff.mode == psic_pkg::PSIC_CLEAR);
          nxt_st.rdata[psic_pkg::SEL_TYPE_BIT] = printer_type_in;
          nxt_st.rdata[psic_pkg::SEL_PRN_BIT] = printer_present_in;
          nxt_st.rdata[psic_pkg::SEL_RATE_BIT] = rate_table_in;
          nxt_st.rdata[4:0] = 5'(PORTS);
        end
        psic_pkg::OFS_IRQ: begin
          // [R12] pending high, posted low; [R23] rest zero
          nxt_st.rdata[psic_pkg::IRQ_PEND_LSB +: psic_pkg::NUM_SRC] = st_ff.pending;
          nxt_st.rdata[psic_pkg::IRQ_POST_LSB +: psic_pkg::NUM_SRC] = st_ff.posted;
          // [R22] read clears posted
          nxt_st.posted = 6'h00;
        end
        default: begin
          // [R6] indexed contents follow index
          if (sl != 3'h7 && idx_ok) begin
            nxt_st.rdata = bank_ff[st_ff.index][sl];
          end
        end
      endcase
    end
    // host write
    if (wr_in) begin
      unique case (addr_in)
        psic_pkg::OFS_SEL: begin
          // [R5] index select
          nxt_st.index = wdata_in[psic_pkg::SEL_IDX_LSB +: 5];
          if (wdata_in[psic_pkg::SEL_CLEAR_BIT]) begin
            // [R1] begin full clear
            nxt_st.mode = psic_pkg::PSIC_CLEAR;
            nxt_st.clr_cnt = 5'h00;
            // [R4] mode taken only with clear
            nxt_st.multi = wdata_in[psic_pkg::SEL_MULTI_BIT];
          end
        end
        psic_pkg::OFS_IRQ: begin
          // [R11] vector and enables; [R23] bits 9,8 dropped
          nxt_st.vector = wdata_in[7:0];
          nxt_st.enable = wdata_in[psic_pkg::IRQ_PEND_LSB +: psic_pkg::NUM_SRC];
        end
        default: begin
        end
      endcase
    end
    // events set pending; set wins over issue
    nxt_st.pending = st_ff.pending | ev;
    // [R19] gated by enable and empty posted
    req = st_ff.pending & st_ff.enable;
    nxt_st.irq = 1'b0;
    if (req != 6'h00 && st_ff.posted == 6'h00 && st_ff.mode == psic_pkg::PSIC_IDLE) begin
      // [R20] highest priority moves to posted
      src = top_src(req);
      nxt_st.pending[3'(5) - src] = ev[3'(5) - src];
      nxt_st.posted[3'(5) - src] = 1'b1;
      nxt_st.irq = 1'b1;
      // [R21] vector plus source number in multi mode
      nxt_st.vec_out = st_ff.multi ? st_ff.vector + 8'(src) : st_ff.vector;
    end
    // clear sequence: pending, posted, enables and vector back to power-up, then idle
    if (st_ff.mode == psic_pkg::PSIC_CLEAR) begin
      nxt_st.clr_cnt = st_ff.clr_cnt + 5'h01;
      nxt_st.pending = 6'h00;
      nxt_st.posted = 6'h00;
      nxt_st.enable = 6'h00;
      nxt_st.vector = psic_pkg::RST_VEC;
      if (st_ff.clr_cnt == 5'(psic_pkg::CLEAR_CYCLES - 1)) begin
        nxt_st.mode = psic_pkg::PSIC_IDLE;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // indexed bank; [R1] cleared by full clear too
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || st_ff.mode == psic_pkg::PSIC_CLEAR) begin
      for (int i = 0; i < psic_pkg::NUM_SLOTS; i++) begin
        for (int j = 0; j < 5; j++) begin
          bank_ff[i][j] <= psic_pkg::RST_WORD;
        end
      end
    end else if (wr_in && slot_of(addr_in) != 3'h7 && idx_ok) begin
      // [R6] write lands in selected slot
      bank_ff[st_ff.index][slot_of(addr_in)] <= wdata_in;
    end
  end

  // outputs straight from flops, clearing_out decoded from the mode flops
  assign rdata_out = st_ff.rdata;
  assign rvalid_out = st_ff.rvalid;
  assign irq_out = st_ff.irq;
  assign vector_out = st_ff.vec_out;
  assign index_out = st_ff.index;
  assign clearing_out = (st_ff.mode == psic_pkg::PSIC_CLEAR);
  assign baud_out = st_ff.baud;
endmodule

// *** rtl/psic_pkg.sv ***
/*
  constants for the port selector and interrupt control block.
  assumes a 16-bit host register port, word addressed by byte offset.
*/
// Overview of operation
// [R1] full clear resets all, reads one meanwhile
// [R2] host polls until full clear reads zero
// [R3] host writes zero to reserved bit
// [R4] vector mode taken only with full clear
// [R5] index selects port, queue or printer
// [R6] indexed registers follow selected index
// [R7] read bit7 printer type, bit6 printer present
// [R8] read bit5 shows jumpered rate table
// [R9] read bits4-0 give port count
// [R10] speed code maps through selected table
// [R11] write: low byte vector, high enables
// [R12] read: pending high byte, posted low
// [R13] six sources in fixed priority order
// [R14] bus error on fetch sets bus fault
// [R15] age or alarm level sets queue service
// [R16] all characters sent sets tx empty
// [R17] carrier or bell transition sets pending
// [R18] printer attention sets printer pending
// [R19] raise only pending, enabled, nothing posted
// [R20] issue highest pending, move to posted
// [R21] multi mode vector plus source number
// [R22] host read of posted clears it
// [R23] unused bits ignore writes, read zero
package psic_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_SEL = 5'h00;
  localparam logic [4:0] OFS_IRQ = 5'h02;
  localparam logic [4:0] OFS_PARAM = 5'h12;
  localparam logic [4:0] OFS_PSTATE = 5'h14;
  localparam logic [4:0] OFS_ADDR_HI = 5'h16;
  localparam logic [4:0] OFS_ADDR_LO = 5'h18;
  localparam logic [4:0] OFS_LEN = 5'h1a;
  // selector fields
  localparam int SEL_CLEAR_BIT = 15;
  localparam int SEL_MULTI_BIT = 13;
  localparam int SEL_IDX_LSB = 4;
  localparam int SEL_TYPE_BIT = 7;
  localparam int SEL_PRN_BIT = 6;
  localparam int SEL_RATE_BIT = 5;
  // index codes
  localparam logic [4:0] IDX_QUEUE = 5'h10;
  localparam logic [4:0] IDX_PRINTER = 5'h11;
  localparam int NUM_SLOTS = 18;
  // irq control fields
  localparam int IRQ_PEND_LSB = 10;
  localparam int IRQ_POST_LSB = 2;
  localparam int NUM_SRC = 6;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_VEC = 8'h00;
  // full clear sequence length in cycles
  localparam int CLEAR_CYCLES = 16;
  // baud codes in whole baud, the half baud rate shown as 134; unused is zero
  localparam logic [3:0] SPEED_LAST_A = 4'hc;
  localparam logic [3:0] SPEED_LAST_B = 4'hb;
  // block mode: idle or full clear in progress
  typedef enum logic [1:0] {
    PSIC_IDLE = 2'b00,
    PSIC_CLEAR = 2'b01
  } psic_mode_e;
endpackage

// *** rtl/psic_rate.sv ***
/*
  baud rate lookup for a four-bit speed code.
  assumes the table select is a static jumper level.
*/
module psic_rate (
  // table and code
  input wire logic table_in,
  input wire logic [3:0] code_in,
  // rate in baud, zero for unused codes
  output logic [15:0] baud_out
);
  // [R10] table lookup
  always_comb begin
    unique case (code_in)
      4'h0: baud_out = table_in ? 16'h0032 : 16'h004b;
      4'h1: baud_out = 16'h006e;
      4'h2: baud_out = 16'h0086; // 134.5 rounds down to 134
      4'h3: baud_out = table_in ? 16'h00c8 : 16'h0096;
      4'h4: baud_out = 16'h012c;
      4'h5: baud_out = 16'h0258;
      4'h6: baud_out = 16'h04b0;
      4'h7: baud_out = table_in ? 16'h041a : 16'h07d0;
      4'h8: baud_out = 16'h0960;
      4'h9: baud_out = 16'h12c0;
      4'ha: baud_out = table_in ? 16'h1c20 : 16'h0708;
      4'hb: baud_out = 16'h2580;
      4'hc: baud_out = table_in ? 16'h0000 : 16'h4b00;
      default: baud_out = 16'h0000;
    endcase
  end
endmodule

// *** tb/psic_top_properties.sv ***
/* checker for the selector and interrupt control block.
   assumes it is bound to psic_top and sees only its ports. */
module psic_top_properties #(
  parameter int PORTS = 16
) (
  // clock, reset, host port
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] wdata_in,
  input wire logic [15:0] rdata_out,
  input wire logic rvalid_out,
  // straps and status
  input wire logic printer_type_in,
  input wire logic printer_present_in,
  input wire logic rate_table_in,
  input wire logic irq_out,
  input wire logic [4:0] index_out,
  input wire logic clearing_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [5:0] run_ff; // clearing cycles seen so far
  logic post_ff; // an issue not yet read back
  logic sel_wr; // selector write
  logic irq_rd; // control read, clears posted
  assign sel_wr = wr_in && addr_in == psic_pkg::OFS_SEL;
  assign irq_rd = rd_in && addr_in == psic_pkg::OFS_IRQ;
  // helpers: read wins over an older issue, so order matters
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      run_ff <= 6'h00;
      post_ff <= 1'b0;
    end else begin
      run_ff <= clearing_out ? run_ff + 6'h01 : 6'h00;
      post_ff <= irq_rd ? 1'b0 : (irq_out ? 1'b1 : post_ff);
    end
  end
  a_clear_start: assert property (
    sel_wr && wdata_in[15] |=> clearing_out) else $error("clear did not start");
  a_clear_length: assert property (
    $fell(clearing_out) |-> run_ff == 6'h10) else $error("clear length wrong");
  a_irq_one_posted: assert property (
    irq_out |-> !post_ff) else $error("irq while posted");
  a_rd_answer: assert property (
    rd_in |=> rvalid_out) else $error("no read answer");
  a_rvalid_cause: assert property (
    rvalid_out |-> $past(rd_in)) else $error("stray read answer");
  a_index_write: assert property (
    sel_wr && !wdata_in[15] |=> index_out == $past(wdata_in[8:4]))
    else $error("index not taken");
  a_sel_config: assert property (
    rd_in && addr_in == psic_pkg::OFS_SEL |=> rdata_out[14:0] ==
    {7'h00, $past(printer_type_in), $past(printer_present_in), $past(rate_table_in),
    5'(PORTS)}) else $error("config read wrong");
  a_icr_zeros: assert property (
    irq_rd |=> rdata_out[9:8] == 2'b00 && rdata_out[1:0] == 2'b00)
    else $error("unused bits set");
endmodule

// *** tb/psic_host.sv ***
/* host model: one-cycle word writes and reads on the register port.
   assumes read data is settled one cycle after the strobe. */
module psic_host (
  // clock
  input wire logic clk_in,
  // register port
  output logic [4:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out,
  input wire logic [15:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus, data never left at a stale value
  initial begin
    addr_out = 5'h1f;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'hffff;
  end
  // write strobe for one edge
  task automatic put(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~v;
  endtask
  // read strobe, data taken after the answer edge
  task automatic get(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    v = rdata_in;
  endtask
  task automatic clear(input logic mv);
    logic [15:0] v;
    put(psic_pkg::OFS_SEL, {1'b1, 1'b0, mv, 13'h0000});
    v = 16'h8000;
    for (int i = 0; i < 40 && v[15]; i++) get(psic_pkg::OFS_SEL, v);
  endtask
endmodule

// *** tb/psic_top_tb.sv ***
/* self-checking bench for the selector and interrupt control block.
   assumes the host model and the checker bound at the foot. */
module psic_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, wr, rd, rv, irq, clr, pt, pp, pr, ber, age, alm, txd, pat;
  logic [4:0] addr, idx, s, o;
  logic [15:0] wd, rdat, carr, bell, baud, r, d;
  logic [3:0] spd;
  logic [7:0] vec, vb;
  logic [5:0] m;
  int num_errors = 0;
  int checks = 0;
  int nirq = 0;
  psic_top #(.PORTS(16)) i_psic_top (.sys_clk_in(clk), .sys_rst_in(rst), .addr_in(addr),
    .wr_in(wr), .rd_in(rd), .wdata_in(wd), .rdata_out(rdat), .rvalid_out(rv),
    .printer_type_in(pt), .printer_present_in(pp), .rate_table_in(pr), .bus_error_in(ber),
    .queue_age_in(age), .queue_alarm_in(alm), .tx_done_in(txd), .carrier_in(carr),
    .bell_in(bell), .printer_attention_in(pat), .speed_code_in(spd), .baud_out(baud),
    .irq_out(irq), .vector_out(vec), .index_out(idx), .clearing_out(clr));
  psic_host i_psic_host (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wd), .rdata_in(rdat));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // expected rate for a code, zero where unused
  function automatic logic [15:0] rate_of(input logic t, input logic [3:0] c);
    case (c)
      4'h0: return t ? 16'h0032 : 16'h004b;
      4'h1: return 16'h006e;
      4'h2: return 16'h0086;
      4'h3: return t ? 16'h00c8 : 16'h0096;
      4'h4: return 16'h012c;
      4'h5: return 16'h0258;
      4'h6: return 16'h04b0;
      4'h7: return t ? 16'h041a : 16'h07d0;
      4'h8: return 16'h0960;
      4'h9: return 16'h12c0;
      4'hb: return 16'h2580;
      4'ha: return t ? 16'h1c20 : 16'h0708;
      4'hc: return t ? 16'h0000 : 16'h4b00;
      default: return 16'h0000;
    endcase
  endfunction
  // pulse sources, source 0 in bit 5; carrier and bell are level toggles
  task automatic fire(input logic [5:0] f);
    logic q;
    q = 1'($urandom_range(1));
    @(posedge clk);
    {ber, txd, pat, age, alm} <= {f[5], f[3], f[0], f[4] & q, f[4] & ~q};
    if (f[2]) carr <= carr ^ (16'h0001 << $urandom_range(15));
    if (f[1]) bell <= bell ^ (16'h0001 << $urandom_range(15));
    @(posedge clk);
    {ber, txd, pat, age, alm} <= 5'h00;
  endtask
  // bounded wait for the request pulse
  task automatic wait_irq();
    for (int n = 0; n < 50 && irq !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0000, irq}, 16'h0001, "irq");
  endtask
  // close the run
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq === 1'b1) nirq++;
  end
  // hang guard, some fifty times the expected run
  initial begin
    #200000;
    num_errors++;
    $display("CHECK FAILED %0t watchdog", $time);
    end_of_test();
  end
  initial begin
    void'($urandom(89));
    {rst, ber, age, alm, txd, pat, spd, carr, bell} = {1'b1, 41'h0};
    {pt, pp, pr} = 3'($urandom_range(7));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({irq, clr, vec, idx}, 16'h0000, "reset");
    i_psic_host.clear(1'b1);
    i_psic_host.get(psic_pkg::OFS_SEL, r);
    chk(r, {8'h00, pt, pp, pr, 5'h10}, "config");
    s = 5'($urandom_range(15));
    o = 5'h12 + 5'(2 * $urandom_range(4));
    d = 16'($urandom);
    i_psic_host.put(psic_pkg::OFS_SEL, {7'h00, s, 4'h0});
    i_psic_host.put(o, d);
    i_psic_host.put(psic_pkg::OFS_SEL, 16'h0110);
    i_psic_host.put(o, ~d);
    i_psic_host.put(psic_pkg::OFS_SEL, 16'h0120);
    i_psic_host.put(o, d);
    i_psic_host.get(o, r);
    chk(r, 16'h0000, "unused slot");
    i_psic_host.put(psic_pkg::OFS_SEL, {7'h00, s, 4'h0});
    i_psic_host.get(o, r);
    chk(r, d, "port slot");
    i_psic_host.put(psic_pkg::OFS_SEL, 16'h0110);
    i_psic_host.get(o, r);
    chk(r, ~d, "printer slot");
    foreach (m[i]) begin
      @(posedge clk);
      spd <= 4'h7 + 4'(i);
      repeat (3) @(posedge clk);
      chk(baud, rate_of(pr, 4'h7 + 4'(i)), "baud");
    end
    vb = 8'($urandom_range(250));
    i_psic_host.put(psic_pkg::OFS_IRQ, {8'h03, vb});
    fire(6'h3f);
    i_psic_host.get(psic_pkg::OFS_IRQ, r);
    chk(r, 16'hfc00, "pending");
    chk(16'(nirq), 16'h0000, "masked");
    i_psic_host.put(psic_pkg::OFS_IRQ, {8'hfc, vb});
    for (int i = 0; i < 6; i++) begin
      wait_irq();
      chk({8'h00, vec}, {8'h00, vb + 8'(i)}, "multi vector");
      repeat (5) @(posedge clk);
      chk(16'(nirq), 16'(i + 1), "one posted");
      i_psic_host.get(psic_pkg::OFS_IRQ, r);
      chk(r, {6'h3f >> (i + 1), 2'h0, 6'h20 >> i, 2'h0}, "issue");
    end
    i_psic_host.put(psic_pkg::OFS_IRQ, 16'h0000);
    fire(6'h02);
    i_psic_host.clear(1'b0);
    i_psic_host.get(psic_pkg::OFS_IRQ, r);
    chk(r, 16'h0000, "clear wipes");
    i_psic_host.put(psic_pkg::OFS_IRQ, {8'hfc, vb});
    repeat (4) begin
      m = 6'h20 >> $urandom_range(5);
      fire(m);
      wait_irq();
      chk({8'h00, vec}, {8'h00, vb}, "single vector");
      i_psic_host.get(psic_pkg::OFS_IRQ, r);
      chk(r, {8'h00, m, 2'h0}, "cause");
    end
    end_of_test();
  end
endmodule
bind psic_top psic_top_properties #(.PORTS(PORTS)) i_psic_top_properties (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_in(wr_in),
  .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .printer_type_in(printer_type_in), .printer_present_in(printer_present_in),
  .rate_table_in(rate_table_in), .irq_out(irq_out), .index_out(index_out),
  .clearing_out(clearing_out));
